// ===== design/pwr_state_pkg.sv
package pwr_state_pkg;
	localparam logic [1:0] SEL_LAN = 2'h0;
	localparam logic [1:0] SEL_ENERGY = 2'h1;
	localparam logic [1:0] SEL_DEEP = 2'h2;
	localparam logic [1:0] SEL_CLKON = 2'h3;
	localparam logic [1:0] SEL_RESET = SEL_DEEP;
	localparam int GPIO_COUNT = 11;
	localparam int LINK_GPIO = 7;
	localparam int WAKE_LAN_BIT = 0;
	localparam int WAKE_ENERGY_BIT = 1;

	typedef enum logic [2:0] {
		ST_UNCONF = 3'h0,
		ST_CONF = 3'h1,
		ST_LAN = 3'h2,
		ST_ENERGY = 3'h3,
		ST_DEEP = 3'h4,
		ST_CLKON = 3'h5
	} pwr_state_type;
endpackage : pwr_state_pkg

// ===== design/usb_power_state_manager.sv
module usb_power_state_manager (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// usb side events, one-cycle pulses
	input wire logic usbReset,
	input wire logic resetPinReq,
	input wire logic configDone,
	input wire logic deconfigure,
	input wire logic suspendReq,
	input wire logic hostResume,
	// software writes
	input wire logic selWrite,
	input wire logic [1:0] selData,
	input wire logic lanWakeEnable,
	input wire logic lanEventsEnabled,
	input wire logic linkUpSelect,
	input wire logic wakeClear,
	input wire logic [10:0] gpioClear,
	// wake sources, levels
	input wire logic lanWake,
	input wire logic goodFrame,
	input wire logic energyDetect,
	input wire logic linkUp,
	input wire logic [10:0] gpioWake,
	// status and control outputs
	output logic [1:0] suspendSel,
	output logic ready,
	output logic configured,
	output logic allModulesOn,
	output logic clocksOn,
	output logic phyPowered,
	output logic suspended,
	output logic remoteWake,
	output logic dropFrames,
	output logic hwReinit,
	output logic [1:0] wakeStatus,
	output logic [10:0] gpioFlags
);
	pwr_state_pkg::pwr_state_type state_r;
	pwr_state_pkg::pwr_state_type state_nxt;
	logic [1:0] sel_r;
	logic [1:0] wakeSts_r;
	logic [10:0] gpioSts_r;
	logic remote_r;
	logic reinit_r;
	logic wasConf_r;
	logic inNormal;
	logic inSuspend;
	logic hardReset;
	logic wakeNow;
	logic pending;
	pwr_state_pkg::pwr_state_type sleepTarget;
	pwr_state_pkg::pwr_state_type wakeTarget;

	wake_bus_if wb ();
	assign wb.state = state_r;
	assign wb.hostResume = hostResume & inSuspend;
	assign wb.lanWake = lanWake & lanWakeEnable;
	// the lan wake enable is a don't care for a good-frame wake
	assign wb.goodFrame = goodFrame & ~lanEventsEnabled;
	assign wb.energyDetect = energyDetect;
	assign wb.linkUp = linkUp;
	assign wb.linkUpSelect = linkUpSelect;
	assign wb.gpioWake = gpioWake;

	wake_filter u_filter (
		.wb(wb)
	);

	assign inNormal = state_r == pwr_state_pkg::ST_UNCONF
		|| state_r == pwr_state_pkg::ST_CONF;
	assign inSuspend = !inNormal;
	assign hardReset = usbReset | resetPinReq;
	assign wakeNow = inSuspend & wb.wakeNow;
	// a flag left set before suspend wakes the device straight away
	assign pending = (|gpioSts_r) | (|wakeSts_r);

	function automatic pwr_state_pkg::pwr_state_type sel_state(
		input logic [1:0] sel
	);
		unique case (sel)
			pwr_state_pkg::SEL_LAN: sel_state = pwr_state_pkg::ST_LAN;
			pwr_state_pkg::SEL_ENERGY: sel_state = pwr_state_pkg::ST_ENERGY;
			pwr_state_pkg::SEL_DEEP: sel_state = pwr_state_pkg::ST_DEEP;
			pwr_state_pkg::SEL_CLKON: sel_state = pwr_state_pkg::ST_CLKON;
		endcase
	endfunction : sel_state

	// unconfigured may only sleep in the deepest variant
	assign sleepTarget = (state_r == pwr_state_pkg::ST_CONF) ?
		sel_state(sel_r) : pwr_state_pkg::ST_DEEP;
	// context is kept: wake returns to the normal flavour we left
	assign wakeTarget = wasConf_r ? pwr_state_pkg::ST_CONF
		: pwr_state_pkg::ST_UNCONF;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			pwr_state_pkg::ST_UNCONF: begin
				if (suspendReq) begin
					state_nxt = sleepTarget;
				end else if (configDone) begin
					state_nxt = pwr_state_pkg::ST_CONF;
				end
			end
			pwr_state_pkg::ST_CONF: begin
				if (deconfigure) begin
					state_nxt = pwr_state_pkg::ST_UNCONF;
				end else if (suspendReq) begin
					state_nxt = sleepTarget;
				end
			end
			pwr_state_pkg::ST_LAN, pwr_state_pkg::ST_ENERGY,
			pwr_state_pkg::ST_DEEP, pwr_state_pkg::ST_CLKON: begin
				if (wakeNow || pending) begin
					state_nxt = wakeTarget;
				end
			end
			default: state_nxt = pwr_state_pkg::ST_UNCONF;
		endcase
		if (hardReset) begin
			state_nxt = pwr_state_pkg::ST_UNCONF;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= pwr_state_pkg::ST_UNCONF;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wasConf_r <= 1'b0;
		end else if (hardReset) begin
			wasConf_r <= 1'b0;
		end else if (inNormal) begin
			// the flavour in force at the suspend edge is the one to return to
			wasConf_r <= state_r == pwr_state_pkg::ST_CONF;
		end
	end

	// deconfigure outranks a software write in the same cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sel_r <= pwr_state_pkg::SEL_RESET;
		end else if (hardReset || deconfigure) begin
			sel_r <= pwr_state_pkg::SEL_RESET;
		end else if (selWrite && inNormal) begin
			sel_r <= selData;
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gpioSts_r <= 11'h000;
			wakeSts_r <= 2'h0;
		end else if (hardReset) begin
			gpioSts_r <= 11'h000;
			wakeSts_r <= 2'h0;
		end else begin
			gpioSts_r <= (gpioSts_r & ~gpioClear)
				| (inSuspend ? wb.gpioHit : 11'h000);
			wakeSts_r[pwr_state_pkg::WAKE_LAN_BIT] <=
				(wakeSts_r[pwr_state_pkg::WAKE_LAN_BIT] & ~wakeClear)
				| wb.lanHit;
			wakeSts_r[pwr_state_pkg::WAKE_ENERGY_BIT] <=
				(wakeSts_r[pwr_state_pkg::WAKE_ENERGY_BIT] & ~wakeClear)
				| wb.energyHit;
		end
	end

	// remote wake pulses only for device-side wake, not host resume
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			remote_r <= 1'b0;
			reinit_r <= 1'b0;
		end else begin
			remote_r <= inSuspend && !hardReset && !wb.hostResume
				&& (wakeNow || pending);
			reinit_r <= hardReset;
		end
	end

	assign suspendSel = sel_r;
	assign ready = inNormal;
	assign configured = state_r == pwr_state_pkg::ST_CONF;
	assign allModulesOn = state_r == pwr_state_pkg::ST_CONF;
	assign clocksOn = inNormal || state_r == pwr_state_pkg::ST_CLKON;
	// deepest variant powers the phy down; its state is lost
	assign phyPowered = state_r != pwr_state_pkg::ST_DEEP;
	assign suspended = inSuspend;
	assign remoteWake = remote_r;
	assign dropFrames = state_r == pwr_state_pkg::ST_CLKON
		&& lanEventsEnabled;
	assign hwReinit = reinit_r;
	assign wakeStatus = wakeSts_r;
	assign gpioFlags = gpioSts_r;

	property p_ready_normal;
		@(posedge mclk) disable iff (!arst_n)
		ready == (state_r == pwr_state_pkg::ST_UNCONF
			|| state_r == pwr_state_pkg::ST_CONF)
			&& (!ready || (clocksOn && phyPowered));
	endproperty
	a_ready_normal: assert property (p_ready_normal)
		else $error("ready differs from normal state");

	property p_reset_unconf;
		@(posedge mclk) disable iff (!arst_n)
		hardReset |=> state_r == pwr_state_pkg::ST_UNCONF && hwReinit;
	endproperty
	a_reset_unconf: assert property (p_reset_unconf)
		else $error("reset did not reach unconfigured");

	property p_unconf_deep;
		@(posedge mclk) disable iff (!arst_n)
		(state_r == pwr_state_pkg::ST_UNCONF && suspendReq && !hardReset)
			|=> state_r == pwr_state_pkg::ST_DEEP;
	endproperty
	a_unconf_deep: assert property (p_unconf_deep)
		else $error("unconfigured suspend not deepest");

	property p_conf_sel;
		@(posedge mclk) disable iff (!arst_n)
		(state_r == pwr_state_pkg::ST_CONF && suspendReq && !deconfigure
			&& !hardReset) |=> state_r == sel_state($past(sel_r));
	endproperty
	a_conf_sel: assert property (p_conf_sel)
		else $error("suspend variant not from select field");

	property p_deconf_sel;
		@(posedge mclk) disable iff (!arst_n)
		deconfigure |=> suspendSel == pwr_state_pkg::SEL_RESET;
	endproperty
	a_deconf_sel: assert property (p_deconf_sel)
		else $error("select not reset on deconfigure");

	property p_deep_gate;
		@(posedge mclk) disable iff (!arst_n)
		(state_r == pwr_state_pkg::ST_DEEP && !hostResume && !pending
			&& !hardReset && gpioWake == 11'h000) |=> suspended;
	endproperty
	a_deep_gate: assert property (p_deep_gate)
		else $error("deepest woke on forbidden source");

	property p_wake_back;
		@(posedge mclk) disable iff (!arst_n)
		(suspended && hostResume && !hardReset) |=>
			ready && (configured == $past(wasConf_r));
	endproperty
	a_wake_back: assert property (p_wake_back)
		else $error("resume returned to wrong normal flavour");

	property p_frame_flag;
		@(posedge mclk) disable iff (!arst_n)
		(state_r == pwr_state_pkg::ST_CLKON && goodFrame
			&& !lanEventsEnabled && !hardReset)
			|=> wakeStatus[pwr_state_pkg::WAKE_LAN_BIT] && ready;
	endproperty
	a_frame_flag: assert property (p_frame_flag)
		else $error("good frame wake not flagged");

	property p_pending;
		@(posedge mclk) disable iff (!arst_n)
		(suspended && (|gpioFlags) && !hardReset) |=> ready;
	endproperty
	a_pending: assert property (p_pending)
		else $error("pending wake did not wake device");

	property p_config;
		@(posedge mclk) disable iff (!arst_n)
		(state_r == pwr_state_pkg::ST_UNCONF && configDone && !suspendReq
			&& !hardReset) |=> configured && allModulesOn;
	endproperty
	a_config: assert property (p_config)
		else $error("configuration did not reach configured");

	property p_sel_locked;
		@(posedge mclk) disable iff (!arst_n)
		(suspended && !deconfigure && !hardReset) |=> $stable(suspendSel);
	endproperty
	a_sel_locked: assert property (p_sel_locked)
		else $error("select changed while suspended");

	property p_energy_only;
		@(posedge mclk) disable iff (!arst_n)
		(state_r == pwr_state_pkg::ST_ENERGY && !hostResume && !pending
			&& !hardReset && !energyDetect && gpioWake == 11'h000)
			|=> suspended;
	endproperty
	a_energy_only: assert property (p_energy_only)
		else $error("energy variant woke on forbidden source");

	property p_frame_drop;
		@(posedge mclk) disable iff (!arst_n)
		(state_r == pwr_state_pkg::ST_CLKON && lanEventsEnabled && !pending
			&& !hardReset) |=> !wakeStatus[pwr_state_pkg::WAKE_LAN_BIT];
	endproperty
	a_frame_drop: assert property (p_frame_drop)
		else $error("frame woke device with lan events enabled");

	property p_deep_quiet;
		@(posedge mclk) disable iff (!arst_n)
		(state_r == pwr_state_pkg::ST_DEEP && !pending && !hardReset
			&& gpioWake == 11'h000) |=> !remoteWake;
	endproperty
	a_deep_quiet: assert property (p_deep_quiet)
		else $error("forbidden source raised remote wake");
endmodule : usb_power_state_manager

// ===== design/wake_bus_if.sv
interface wake_bus_if;
	logic [2:0] state;
	logic hostResume;
	logic lanWake;
	logic goodFrame;
	logic energyDetect;
	logic linkUp;
	logic linkUpSelect;
	logic [10:0] gpioWake;
	logic wakeNow;
	logic [10:0] gpioHit;
	logic lanHit;
	logic energyHit;

	modport filter (
		input state, hostResume, lanWake, goodFrame, energyDetect, linkUp,
		input linkUpSelect, gpioWake,
		output wakeNow, gpioHit, lanHit, energyHit
	);
	modport manager (
		output state, hostResume, lanWake, goodFrame, energyDetect, linkUp,
		output linkUpSelect, gpioWake,
		input wakeNow, gpioHit, lanHit, energyHit
	);
endinterface : wake_bus_if

// ===== design/wake_filter.sv
module wake_filter (
	wake_bus_if.filter wb
);
	logic inLan;
	logic inEnergy;
	logic inClkOn;
	logic [10:0] pinMask;
	logic linkOk;

	assign inLan = wb.state == pwr_state_pkg::ST_LAN;
	assign inEnergy = wb.state == pwr_state_pkg::ST_ENERGY;
	assign inClkOn = wb.state == pwr_state_pkg::ST_CLKON;
	// link-up wake only where the table permits it
	assign linkOk = wb.linkUpSelect & wb.linkUp & (inLan | inClkOn);
	// with link-up selected the gpio7 pin itself is ignored
	assign pinMask = wb.linkUpSelect ?
		~(11'h001 << pwr_state_pkg::LINK_GPIO) : 11'h7FF;
	assign wb.gpioHit = (wb.gpioWake & pinMask)
		| ({11{linkOk}} & (11'h001 << pwr_state_pkg::LINK_GPIO));
	assign wb.lanHit = (inLan & wb.lanWake) | (inClkOn & wb.goodFrame);
	assign wb.energyHit = inEnergy & wb.energyDetect;
	// frames, lan and energy wakes outside their variant count for nothing
	assign wb.wakeNow = wb.hostResume | wb.lanHit | wb.energyHit
		| (|wb.gpioHit);
endmodule : wake_filter

// ===== tb/test_usb_power_state_manager.sv
module test_usb_power_state_manager;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int URST = 0, CFG = 1, DEC = 2, SUS = 3, RES = 4, SEL = 5;
	logic mclk, arst_n, resetPinReq, lanEv, wakeClear;
	logic [5:0] src;
	logic usbReset, configDone, deconfigure, suspendReq, hostResume;
	logic selWrite, ready, configured, allModulesOn, clocksOn, phyPowered;
	logic suspended, remoteWake, dropFrames, hwReinit, lanEn, luSel;
	logic [1:0] selData, suspendSel, wakeStatus;
	logic [10:0] gpioFlags;
	int errors = 0;
	int n_checks = 0;
	// per variant: bad source, good source, expected status and pin flags
	logic [1:0] tSel [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
	int tBad [5] = '{1, 3, 0, 2, 2};
	int tGood [5] = '{0, 2, 5, 1, 3};
	logic [1:0] tWs [5] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h0};
	logic [10:0] tGf [5] = '{11'h000, 11'h000, 11'h008, 11'h000, 11'h080};

	usb_power_state_manager dut_u (
		.mclk, .arst_n, .usbReset, .resetPinReq, .configDone, .deconfigure,
		.suspendReq, .hostResume, .selWrite, .selData,
		.lanWakeEnable(lanEn), .lanEventsEnabled(lanEv), .linkUpSelect(luSel),
		.wakeClear, .gpioClear({11{wakeClear}}), .lanWake(src[0]),
		.goodFrame(src[1]), .energyDetect(src[2]), .linkUp(src[3]),
		.gpioWake({3'h0, src[4], 3'h0, src[5], 3'h0}), .suspendSel, .ready,
		.configured, .allModulesOn, .clocksOn, .phyPowered, .suspended,
		.remoteWake, .dropFrames, .hwReinit, .wakeStatus, .gpioFlags
	);
	usb_host_model host_u (
		.mclk, .usbReset, .configDone, .deconfigure, .suspendReq,
		.hostResume, .selWrite, .selData
	);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic finish_test();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	// sticky flags count as pending wakes, so clear before suspending
	task automatic clearAll();
		src = 6'h00;
		wakeClear = 1'b1;
		@(negedge mclk);
		wakeClear = 1'b0;
	endtask : clearAll

	initial begin
		repeat (5000) @(posedge mclk);
		errors++;
		finish_test();
	end

	initial begin
		arst_n = 1'b0;
		resetPinReq = 1'b0;
		lanEv = 1'b0;
		lanEn = 1'b1;
		luSel = 1'b1;
		wakeClear = 1'b0;
		src = 6'h00;
		repeat (3) @(negedge mclk);
		arst_n = 1'b1;
		@(negedge mclk);
		chk({ready, allModulesOn}, 2'h2);
		chk(suspendSel, 2'h2);
		host_u.send(CFG, 2'h0);
		chk({configured, allModulesOn}, 2'h3);
		$display("test reset_config done");
		for (int i = 0; i < 5; i++) begin
			// a good-frame wake must not lean on the lan enable
			lanEn = tSel[i] != 2'h3;
			host_u.send(SEL, tSel[i]);
			host_u.send(SUS, 2'h0);
			chk({suspended, ready}, 2'h2);
			chk(phyPowered, tSel[i] != 2'h2);
			chk(clocksOn, tSel[i] == 2'h3);
			src = 6'h01 << tBad[i];
			repeat (3) @(negedge mclk);
			chk({suspended, wakeStatus}, 3'h4);
			src = 6'h01 << tGood[i];
			@(negedge mclk);
			chk({ready, remoteWake, configured}, 3'h7);
			chk(phyPowered, 1'b1);
			chk(wakeStatus, tWs[i]);
			chk(gpioFlags, tGf[i]);
			chk(suspendSel, tSel[i]);
			clearAll();
		end
		lanEn = 1'b1;
		$display("test variants done");
		host_u.send(SEL, 2'h3);
		lanEv = 1'b1;
		host_u.send(SUS, 2'h0);
		chk(dropFrames, 1'b1);
		src = 6'h02;
		@(negedge mclk);
		src = 6'h00;
		chk({suspended, wakeStatus}, 3'h4);
		host_u.send(RES, 2'h0);
		chk({ready, remoteWake}, 2'h2);
		lanEv = 1'b0;
		host_u.send(DEC, 2'h0);
		chk({configured, suspendSel}, 3'h2);
		host_u.send(SEL, 2'h0);
		host_u.send(SUS, 2'h0);
		chk(phyPowered, 1'b0);
		host_u.send(SEL, 2'h1);
		chk(suspendSel, 2'h0);
		host_u.send(RES, 2'h0);
		chk({ready, configured}, 2'h2);
		$display("test deconfig done");
		host_u.send(SUS, 2'h0);
		src = 6'h20;
		@(negedge mclk);
		src = 6'h00;
		chk(gpioFlags, 11'h008);
		host_u.send(SUS, 2'h0);
		chk(suspended, 1'b1);
		@(negedge mclk);
		chk({ready, suspended, remoteWake}, 3'h5);
		clearAll();
		$display("test pending done");
		host_u.send(SUS, 2'h0);
		host_u.send(URST, 2'h0);
		chk({ready, suspended, hwReinit}, 3'h5);
		host_u.send(SEL, 2'h1);
		host_u.send(SUS, 2'h0);
		resetPinReq = 1'b1;
		@(negedge mclk);
		resetPinReq = 1'b0;
		chk({ready, suspendSel, hwReinit}, 4'hD);
		$display("test hard_reset done");
		host_u.send(CFG, 2'h0);
		host_u.send(SEL, 2'h0);
		lanEn = 1'b0;
		host_u.send(SUS, 2'h0);
		// gated lan wake and a masked gpio7 pin must both be ignored
		src = 6'h11;
		repeat (2) @(negedge mclk);
		chk({suspended, wakeStatus, gpioFlags}, 14'h2000);
		luSel = 1'b0;
		@(negedge mclk);
		chk({ready, remoteWake, configured}, 3'h7);
		chk({wakeStatus, gpioFlags}, 13'h0080);
		clearAll();
		luSel = 1'b1;
		lanEn = 1'b1;
		$display("test enables done");
		finish_test();
	end
endmodule : test_usb_power_state_manager

// ===== tb/usb_host_model.sv
module usb_host_model (
	// clock
	input wire logic mclk,
	// requests to the device
	output logic usbReset,
	output logic configDone,
	output logic deconfigure,
	output logic suspendReq,
	output logic hostResume,
	output logic selWrite,
	output logic [1:0] selData
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] req;
	assign {selWrite, hostResume, suspendReq} = req[5:3];
	assign {deconfigure, configDone, usbReset} = req[2:0];
	initial begin
		req = 6'h00;
		selData = 2'h0;
	end
	// one-cycle request; select data goes stale once the strobe drops
	task automatic send(input int k, input logic [1:0] v);
		@(negedge mclk);
		selData = v;
		req[k] = 1'b1;
		@(negedge mclk);
		req = 6'h00;
		selData = ~v;
	endtask : send
endmodule : usb_host_model
